// ===== hw/zism_err_pwm.sv
// Error pin coder: PWM pattern on an active-low error pin.
// Assumes error inputs are already latched by the caller.
`timescale 1ns/10ps
module zism_err_pwm #(
    parameter int PWM_CYC = zism_pkg::PWM_CYC
) (
    // Clock and reset
    input  wire logic clock_i,
    input  wire logic rst_n_i,
    // Error causes
    input  wire logic amp_err_i,
    input  wire logic freq_err_i,
    input  wire logic fault_i,
    // Pin level, low means error
    output logic      pin_o
);
    localparam int CW     = $clog2(PWM_CYC);
    localparam int AMP_LO = PWM_CYC * zism_pkg::PWM_AMP_PCT / 100;
    localparam int FRQ_LO = PWM_CYC * zism_pkg::PWM_FREQ_PCT / 100;

    logic [CW-1:0] cnt_r;

    always_ff @(posedge clock_i) begin
        if (!rst_n_i || cnt_r == CW'(PWM_CYC - 1)) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_r + 1'b1;
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            pin_o <= 1'b1;
        end else if (fault_i) begin
            pin_o <= 1'b0;
        end else if (amp_err_i) begin
            pin_o <= !(cnt_r < CW'(AMP_LO));
        end else if (freq_err_i) begin
            pin_o <= !(cnt_r < CW'(FRQ_LO));
        end else begin
            pin_o <= 1'b1;
        end
    end

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);
    chk_pin_fault: assert property (fault_i |=> !pin_o)
        else $error("error pin not low on fault");
    chk_pin_idle:  assert property (!fault_i && !amp_err_i && !freq_err_i |=> pin_o)
        else $error("error pin low without error");
endmodule : zism_err_pwm

// ===== hw/zism_monitor.sv
// Zero index placement, A/B/Z release and amplitude/frequency monitoring.
// Assumes inputs synchronous to clock_i; config bytes arrive on the cfg port
// from the EEPROM loader or serial interface; cfg_done_i marks completion.
`timescale 1ns/10ps
// Overview of operation
// - Counter-reset-by-zero bit set: zero signal clears the period counter.
// - Output-delay bit set: A/B/Z held back 5 ms after configuration.
// - A, B and Z are driven high while the output delay runs.
// - Output-delay bit clear: incremental output starts right after configuration.
// - Zero placed at position code times 11.25 degrees, codes 0 to 31.
// - Zero index output only when both zero-release pins enable it.
// - Zero length: code 0 is 90, 1 is 180, 2 and 3 synchronised.
// - Gating field picks the A/B state in which Z is asserted, in synchronised length codes 2 and 3 only.
// - Method bit: max of sin/cos vs threshold, or sum of squares window.
// - Amplitude error reported only when its enable bit is set.
// - Frequency error reported only when its enable bit is set.
// - Frequency monitored only at resolutions of 16 and above.
// - Error pin: high idle, 75% low amplitude, 50% low frequency, low fault.
// - Amplitude error stops conversion, freezes outputs, excludes frequency error.
// - Errors latched until next sensor data readout, then cleared.
module zism_monitor #(
    parameter int AMP_W     = 10,
    parameter int CNT_W     = 24,
    parameter int DELAY_CYC = zism_pkg::DELAY_CYC,
    parameter int PWM_CYC   = zism_pkg::PWM_CYC
) (
    // Clock and reset
    input  wire logic                         clock_i,
    input  wire logic                         rst_n_i,
    // Configuration port
    input  wire logic                         cfg_we_i,
    input  wire logic [7:0]                   cfg_addr_i,
    input  wire logic [7:0]                   cfg_wdata_i,
    input  wire logic                         cfg_done_i,
    output logic      [7:0]                   cfg_rdata_o,
    // Interpolator state
    input  wire logic                         quad_a_i,
    input  wire logic                         quad_b_i,
    input  wire logic [zism_pkg::PHASE_W-1:0] phase_i,
    input  wire logic                         count_up_i,
    input  wire logic                         count_dn_i,
    input  wire logic [13:0]                  resolution_i,
    // Zero release pins
    input  wire logic                         zero_release_pos_i,
    input  wire logic                         zero_release_neg_i,
    // Monitoring inputs
    input  wire logic [AMP_W-1:0]             sin_abs_i,
    input  wire logic [AMP_W-1:0]             cos_abs_i,
    input  wire logic                         freq_over_i,
    input  wire logic                         readout_i,
    input  wire logic                         config_fault_i,
    input  wire logic                         undervolt_i,
    // Incremental outputs
    output logic                              a_o,
    output logic                              b_o,
    output logic                              z_o,
    output logic      [CNT_W-1:0]             period_count_o,
    // Error reporting
    output logic                              error_pin_low_o,
    output logic                              amp_error_o,
    output logic                              freq_error_o
);
    // ------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------
    logic [7:0] zero_position_config_r;
    logic [7:0] zero_and_counter_control_r;
    logic [7:0] zero_gating_and_error_enable_r;
    logic [7:0] amplitude_monitor_config_r;

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            zero_position_config_r         <= zism_pkg::REG_RST;
            zero_and_counter_control_r     <= zism_pkg::REG_RST;
            zero_gating_and_error_enable_r <= zism_pkg::REG_RST;
            amplitude_monitor_config_r     <= zism_pkg::REG_RST;
        end else if (cfg_we_i) begin
            unique case (cfg_addr_i)
                zism_pkg::ADDR_ZERO_POSITION_CODE:  zero_position_config_r         <= cfg_wdata_i;
                zism_pkg::ADDR_ZCTL:  zero_and_counter_control_r     <= cfg_wdata_i;
                zism_pkg::ADDR_ZGATE: zero_gating_and_error_enable_r <= cfg_wdata_i;
                zism_pkg::ADDR_AMON:  amplitude_monitor_config_r     <= cfg_wdata_i;
                default: ;
            endcase
        end
    end

    // Unmapped offsets read as zero
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            cfg_rdata_o <= 8'h00;
        end else begin
            unique case (cfg_addr_i)
                zism_pkg::ADDR_ZERO_POSITION_CODE:  cfg_rdata_o <= zero_position_config_r;
                zism_pkg::ADDR_ZCTL:  cfg_rdata_o <= zero_and_counter_control_r;
                zism_pkg::ADDR_ZGATE: cfg_rdata_o <= zero_gating_and_error_enable_r;
                zism_pkg::ADDR_AMON:  cfg_rdata_o <= amplitude_monitor_config_r;
                default:              cfg_rdata_o <= 8'h00;
            endcase
        end
    end

    logic                        counter_reset_by_zero;
    logic                        output_delay_enable;
    logic [1:0]                  zero_length_select;
    logic [zism_pkg::ZERO_POSITION_CODE_W-1:0] zero_position_code;
    logic [1:0]                  zero_gating_state;
    logic                        amplitude_error_enable;
    logic                        frequency_error_enable;
    logic                        amplitude_method_select;
    logic [1:0]                  amplitude_threshold_select;

    assign counter_reset_by_zero      = zero_and_counter_control_r[zism_pkg::CBZ_BIT];
    assign output_delay_enable        = zero_and_counter_control_r[zism_pkg::DELAY_BIT];
    assign zero_length_select         = zero_and_counter_control_r[zism_pkg::ZLEN_LSB +: 2];
    assign zero_position_code         = zero_position_config_r[zism_pkg::ZERO_POSITION_CODE_LSB +: zism_pkg::ZERO_POSITION_CODE_W];
    assign zero_gating_state          = zero_gating_and_error_enable_r[zism_pkg::GATE_LSB +: 2];
    assign amplitude_error_enable     = zero_gating_and_error_enable_r[zism_pkg::AMPLITUDE_ERROR_ENABLE_BIT];
    assign frequency_error_enable     = zero_gating_and_error_enable_r[zism_pkg::FREQUENCY_ERROR_ENABLE_BIT];
    assign amplitude_method_select    = amplitude_monitor_config_r[zism_pkg::AMETH_BIT];
    assign amplitude_threshold_select = amplitude_monitor_config_r[zism_pkg::ATHR_LSB +: 2];

    // ------------------------------------------------------------
    // Zero signal
    // ------------------------------------------------------------
    logic zero_raw;
    logic zero_prev_r;
    logic zero_rise;
    logic zero_release;

    zism_zero_gen u_zero (
        .clock_i    (clock_i),
        .rst_n_i    (rst_n_i),
        .phase_i    (phase_i),
        .quad_a_i   (quad_a_i),
        .quad_b_i   (quad_b_i),
        .pos_code_i (zero_position_code),
        .len_sel_i  (zero_length_select),
        .gate_i     (zero_gating_state),
        .zero_o     (zero_raw)
    );

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            zero_prev_r <= 1'b0;
        end else begin
            zero_prev_r <= zero_raw;
        end
    end

    assign zero_rise    = zero_raw && !zero_prev_r;
    assign zero_release = zero_release_pos_i && !zero_release_neg_i;

    // ------------------------------------------------------------
    // Amplitude check
    // ------------------------------------------------------------
    localparam longint FULL = (longint'(1) << AMP_W) - 1;

    logic [AMP_W-1:0] amp_max;
    longint           ssq;
    longint           thr;
    logic             amp_bad;

    assign amp_max = (sin_abs_i > cos_abs_i) ? sin_abs_i : cos_abs_i;

    always_comb begin
        ssq = longint'(sin_abs_i) * longint'(sin_abs_i) + longint'(cos_abs_i) * longint'(cos_abs_i);
        thr = longint'(zism_pkg::amp_thr_pm(amplitude_method_select, amplitude_threshold_select));
        if (amplitude_method_select) begin
            amp_bad = (ssq * 1000000 < thr * thr * FULL * FULL)
                   || (ssq * 1000000 > longint'(zism_pkg::AMAX_PM * zism_pkg::AMAX_PM) * FULL * FULL);
        end else begin
            amp_bad = longint'(amp_max) * 1000 < thr * FULL;
        end
    end

    // ------------------------------------------------------------
    // Error latches
    // ------------------------------------------------------------
    logic amp_err_r;
    logic freq_err_r;
    logic amp_set;
    logic freq_set;

    assign amp_set  = amp_bad && amplitude_error_enable;
    // Frequency error needs enable, resolution 16 up and no amplitude error
    assign freq_set = freq_over_i && frequency_error_enable
                   && resolution_i >= 14'(zism_pkg::MIN_RES)
                   && !amp_err_r && !amp_set;

    // Set wins over a readout clear in the same cycle
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            amp_err_r <= 1'b0;
        end else if (amp_set) begin
            amp_err_r <= 1'b1;
        end else if (readout_i) begin
            amp_err_r <= 1'b0;
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            freq_err_r <= 1'b0;
        end else if (amp_set) begin
            freq_err_r <= 1'b0;
        end else if (freq_set) begin
            freq_err_r <= 1'b1;
        end else if (readout_i) begin
            freq_err_r <= 1'b0;
        end
    end

    assign amp_error_o  = amp_err_r;
    assign freq_error_o = freq_err_r;

    zism_err_pwm #(
        .PWM_CYC (PWM_CYC)
    ) u_pwm (
        .clock_i    (clock_i),
        .rst_n_i    (rst_n_i),
        .amp_err_i  (amp_err_r),
        .freq_err_i (freq_err_r),
        .fault_i    (config_fault_i || undervolt_i),
        .pin_o      (error_pin_low_o)
    );

    // ------------------------------------------------------------
    // Output release sequencing
    // ------------------------------------------------------------
    localparam int DW = $clog2(DELAY_CYC + 1);

    zism_pkg::zism_state_t state_r;
    logic [DW-1:0]         dly_cnt_r;

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            state_r <= zism_pkg::ST_WAIT;
        end else begin
            unique case (state_r)
                zism_pkg::ST_WAIT:
                    if (cfg_done_i) begin
                        state_r <= output_delay_enable ? zism_pkg::ST_DELAY
                                                       : zism_pkg::ST_RUN;
                    end
                zism_pkg::ST_DELAY:
                    if (dly_cnt_r == DW'(DELAY_CYC - 1)) begin
                        state_r <= zism_pkg::ST_RUN;
                    end
                zism_pkg::ST_RUN: ;
                default: state_r <= zism_pkg::ST_WAIT;
            endcase
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i || state_r != zism_pkg::ST_DELAY) begin
            dly_cnt_r <= '0;
        end else begin
            dly_cnt_r <= dly_cnt_r + 1'b1;
        end
    end

    // Amplitude error freezes the lines at their last state
    always_ff @(posedge clock_i) begin
        if (!rst_n_i || state_r != zism_pkg::ST_RUN) begin
            a_o <= 1'b1;
            b_o <= 1'b1;
            z_o <= 1'b1;
        end else if (!amp_err_r) begin
            a_o <= quad_a_i;
            b_o <= quad_b_i;
            z_o <= zero_raw && zero_release;
        end
    end

    // ------------------------------------------------------------
    // Period counter
    // ------------------------------------------------------------
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            period_count_o <= '0;
        end else if (!amp_err_r) begin
            if (counter_reset_by_zero && zero_rise) begin
                period_count_o <= '0;
            end else if (count_up_i && !count_dn_i) begin
                period_count_o <= period_count_o + 1'b1;
            end else if (count_dn_i && !count_up_i) begin
                period_count_o <= period_count_o - 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);
    chk_zero_clears_cnt: assert property (counter_reset_by_zero && zero_rise && !amp_err_r
        |=> period_count_o == '0) else $error("period counter not cleared on zero");
    chk_delay_lines_high: assert property (state_r == zism_pkg::ST_DELAY |-> a_o && b_o && z_o)
        else $error("outputs not high during delay");
    chk_delay_length: assert property (state_r == zism_pkg::ST_RUN && $past(state_r) == zism_pkg::ST_DELAY
        |-> $past(dly_cnt_r) == DW'(DELAY_CYC - 1)) else $error("output delay wrong length");
    chk_no_delay_start: assert property (state_r == zism_pkg::ST_WAIT && cfg_done_i && !output_delay_enable
        |=> state_r == zism_pkg::ST_RUN) else $error("output not released at once");
    chk_zero_suppress: assert property (state_r == zism_pkg::ST_RUN && !amp_err_r && !zero_release
        |=> !z_o) else $error("zero index not suppressed");
    chk_amp_enable: assert property (!amplitude_error_enable && !amp_err_r |=> !amp_err_r)
        else $error("amplitude error while disabled");
    chk_freq_enable: assert property (!frequency_error_enable && !freq_err_r |=> !freq_err_r)
        else $error("frequency error while disabled");
    chk_freq_low_res: assert property (resolution_i < 14'(zism_pkg::MIN_RES) && !freq_err_r
        |=> !freq_err_r) else $error("frequency error at low resolution");
    chk_amp_freeze: assert property (amp_err_r && state_r == zism_pkg::ST_RUN
        |=> $stable(a_o) && $stable(b_o) && $stable(period_count_o)) else $error("outputs moved during amp error");
    chk_err_exclusive: assert property (amp_err_r |-> !freq_err_r)
        else $error("frequency error beside amplitude error");
    chk_err_latched: assert property (amp_err_r && !readout_i |=> amp_err_r)
        else $error("amplitude error dropped without readout");
    cov_delay_done: cover property (state_r == zism_pkg::ST_DELAY ##1 state_r == zism_pkg::ST_RUN);
    cov_amp_err:    cover property (!amp_err_r ##1 amp_err_r);
    cov_freq_err:   cover property (!freq_err_r ##1 freq_err_r);
    cov_z_pulse:    cover property (!z_o ##1 z_o ##1 !z_o);
endmodule : zism_monitor

// ===== hw/zism_pkg.sv
// Shared constants of the zero index and signal monitor block.
// Assumes one 20 MHz clock; angle inputs scaled 256 counts per period.
package zism_pkg;
    // ------------------------------------------------------------
    // Register offsets and reset value
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_ZERO_POSITION_CODE  = 8'h01;
    localparam logic [7:0] ADDR_ZCTL  = 8'h02;
    localparam logic [7:0] ADDR_ZGATE = 8'h03;
    localparam logic [7:0] ADDR_AMON  = 8'h0c;
    localparam logic [7:0] REG_RST    = 8'h00;
    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int ZERO_POSITION_CODE_LSB  = 0;
    localparam int ZERO_POSITION_CODE_W    = 5;
    localparam int ZLEN_LSB  = 0;
    localparam int CBZ_BIT   = 4;
    localparam int DELAY_BIT = 7;
    localparam int FREQUENCY_ERROR_ENABLE_BIT  = 0;
    localparam int AMPLITUDE_ERROR_ENABLE_BIT  = 1;
    localparam int GATE_LSB  = 4;
    localparam int ATHR_LSB  = 0;
    localparam int AMETH_BIT = 2;
    // ------------------------------------------------------------
    // Angle scaling: 256 counts per 360 deg, 11.25 deg is 8 counts
    // ------------------------------------------------------------
    localparam int         PHASE_W     = 8;
    localparam int         ZSTEP_SHIFT = 3;
    localparam logic [8:0] LEN_90      = 9'h040;
    localparam logic [8:0] LEN_180     = 9'h080;
    localparam int         MIN_RES     = 16;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_HZ       = 20_000_000;
    localparam int DELAY_US     = 5000;
    localparam int DELAY_CYC    = DELAY_US * (CLK_HZ / 1_000_000);
    localparam int PWM_US       = 1000;
    localparam int PWM_CYC      = PWM_US * (CLK_HZ / 1_000_000);
    localparam int PWM_AMP_PCT  = 75;
    localparam int PWM_FREQ_PCT = 50;
    // ------------------------------------------------------------
    // Amplitude thresholds, per mille of full scale
    // ------------------------------------------------------------
    localparam int AMAX_PM = 900;
    typedef enum logic [1:0] {
        ST_WAIT  = 2'b00,
        ST_DELAY = 2'b01,
        ST_RUN   = 2'b11
    } zism_state_t;
    function automatic int amp_thr_pm(input logic meth, input logic [1:0] sel);
        return meth ? 200 + 100 * int'(sel) : 600 + 40 * int'(sel);
    endfunction : amp_thr_pm
endpackage : zism_pkg

// ===== hw/zism_zero_gen.sv
// Zero window generator: places and shapes the raw zero signal.
// Assumes phase_i counts 256 per signal period, wrapping.
`timescale 1ns/10ps
module zism_zero_gen (
    // Clock and reset
    input  wire logic                          clock_i,
    input  wire logic                          rst_n_i,
    // Angle and quadrature state
    input  wire logic [zism_pkg::PHASE_W-1:0]  phase_i,
    input  wire logic                          quad_a_i,
    input  wire logic                          quad_b_i,
    // Configuration
    input  wire logic [zism_pkg::ZERO_POSITION_CODE_W-1:0]   pos_code_i,
    input  wire logic [1:0]                    len_sel_i,
    input  wire logic [1:0]                    gate_i,
    // Raw zero
    output logic                               zero_o
);
    logic [zism_pkg::PHASE_W-1:0] offs;
    logic                         in90;
    logic                         in180;
    logic                         match;
    logic                         sync;
    logic                         zero_nxt;

    assign offs  = phase_i - {pos_code_i, 3'h0};
    assign in90  = {1'b0, offs} < zism_pkg::LEN_90;
    assign in180 = {1'b0, offs} < zism_pkg::LEN_180;
    assign match = (quad_b_i == ~gate_i[0]) && (quad_a_i == ~gate_i[1]);
    assign sync  = len_sel_i[1];

    always_comb begin
        if (sync) begin
            zero_nxt = in90 && match;
        end else begin
            zero_nxt = len_sel_i[0] ? in180 : in90;
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            zero_o <= 1'b0;
        end else begin
            zero_o <= zero_nxt;
        end
    end

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);
    chk_sync_gate:  assert property (sync && !match |=> !zero_o)
        else $error("zero outside gating state in sync mode");
    chk_len_90:     assert property (len_sel_i == 2'h0 && !in90 |=> !zero_o)
        else $error("zero longer than 90 deg");
endmodule : zism_zero_gen

// ===== verification/test_zero_index_and_signal_monitor.sv
// Bench: config writes, delayed release, zero placement, error flags.
// Assumes shortened delay (20) and PWM (8) counts at the instance.
`timescale 1ns/10ps
module test_zero_index_and_signal_monitor;
    logic clock_i = 0, rst_n_i = 0, we = 0, done = 0, qa = 0, qb = 0, zp = 0, zn = 0, fo = 0, ro = 0, cu = 0, cf = 0;
    logic [7:0] addr = 8'h00, wd = 8'h00, rd, ph = 8'h00, k;
    logic [7:0] zph [4] = '{8'h1f, 8'h20, 8'h5f, 8'h60};
    logic [3:0] zex = 4'b0110;
    logic [13:0] res = 14'h0008;
    logic [9:0] amp = 10'h3ff;
    logic a, b, z, el, ae, fe;
    logic [23:0] pc, cnt;
    int n_errors = 0, total_checks = 0;
    always #25 clock_i = ~clock_i;
    zism_monitor #(.DELAY_CYC(20), .PWM_CYC(8)) u_zism_monitor (.clock_i(clock_i), .rst_n_i(rst_n_i),
        .cfg_we_i(we), .cfg_addr_i(addr), .cfg_wdata_i(wd), .cfg_done_i(done), .cfg_rdata_o(rd),
        .quad_a_i(qa), .quad_b_i(qb), .phase_i(ph), .count_up_i(cu), .count_dn_i(1'b0),
        .resolution_i(res), .zero_release_pos_i(zp), .zero_release_neg_i(zn), .sin_abs_i(amp),
        .cos_abs_i(amp), .freq_over_i(fo), .readout_i(ro), .config_fault_i(cf), .undervolt_i(1'b0),
        .a_o(a), .b_o(b), .z_o(z), .period_count_o(pc), .error_pin_low_o(el), .amp_error_o(ae),
        .freq_error_o(fe));
    zism_counter_model u_zism_counter_model (.clock_i(clock_i), .rst_n_i(rst_n_i), .a_i(a), .b_i(b),
        .z_i(z), .count_o(cnt));
    task automatic cyc(input int n);
        repeat (n) @(posedge clock_i);
        #1;
    endtask : cyc
    task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
        total_checks++;
        if (g !== e) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", s, e, g);
        end
    endtask : chk
    task automatic wr(input logic [7:0] ad, input logic [7:0] d);
        we = 1; addr = ad; wd = d;
        cyc(1);
        we = 0;
        // Idle edge so a following write never re-raises the strobe in the same step
        cyc(1);
    endtask : wr
    task automatic rdc(input logic [7:0] ad, input logic [7:0] e);
        addr = ad;
        cyc(1);
        chk("readback", e, rd);
    endtask : rdc
    task automatic stop_test;
        $display("errors %0d checks %0d", n_errors, total_checks);
        if (n_errors == 0 && total_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : stop_test
    // Low cycles of the error pin over one PWM period
    task automatic pwm_lows;
        k = 8'h00;
        repeat (8) begin
            cyc(1);
            if (el !== 1'b1) k = k + 8'h01;
        end
    endtask : pwm_lows
    initial begin
        cyc(2);
        rst_n_i = 1;
        rdc(8'h05, 8'h00);
        wr(8'h02, 8'h90);
        wr(8'h01, 8'h04);
        wr(8'h03, 8'h03);
        wr(8'h0c, 8'h00);
        rdc(8'h02, 8'h90);
        done = 1;
        cyc(10);
        chk("abz held", 8'h07, {5'h0, a, b, z});
        chk("counter idle", 8'h00, cnt[7:0]);
        cyc(30);
        chk("abz run", 8'h00, {5'h0, a, b, z});
        cu = 1;
        cyc(5);
        cu = 0;
        chk("period count", 8'h05, pc[7:0]);
        zp = 1;
        foreach (zph[i]) begin
            ph = zph[i];
            cyc(3);
            chk("z_o", {7'h0, zex[i]}, {7'h0, z});
        end
        chk("period cleared", 8'h00, pc[7:0]);
        wr(8'h02, 8'h91);
        ph = 8'h9f;
        cyc(3);
        chk("z_o 180", 8'h01, {7'h0, z});
        wr(8'h02, 8'h92);
        ph = 8'h20;
        cyc(3);
        chk("z_o sync", 8'h00, {7'h0, z});
        qa = 1; qb = 1;
        cyc(3);
        chk("z_o gated", 8'h01, {7'h0, z});
        zp = 0;
        cyc(3);
        chk("z_o off", 8'h00, {7'h0, z});
        fo = 1;
        cyc(3);
        chk("freq low res", 8'h00, {7'h0, fe});
        res = 14'h0010;
        cyc(3);
        chk("freq err", 8'h01, {7'h0, fe});
        pwm_lows();
        chk("pwm freq", 8'h04, k);
        fo = 0; ro = 1;
        cyc(1);
        ro = 0;
        cyc(1);
        chk("cleared", 8'h00, {7'h0, fe});
        fo = 1; amp = 10'h000;
        cyc(3);
        chk("amp excl", 8'h02, {6'h0, ae, fe});
        pwm_lows();
        chk("pwm amp", 8'h06, k);
        qa = 0;
        cyc(3);
        chk("a frozen", 8'h01, {7'h0, a});
        cf = 1;
        cyc(2);
        chk("pin fault", 8'h00, {7'h0, el});
        // Second reset: delay bit back at zero, so release follows at once
        rst_n_i = 0;
        cyc(2);
        rst_n_i = 1;
        cf = 0;
        cyc(3);
        chk("abz no delay", 8'h02, {5'h0, a, b, z});
        chk("flags disabled", 8'h00, {6'h0, ae, fe});
        stop_test();
    end
    initial begin
        #100000;
        n_errors++;
        stop_test();
    end
endmodule : test_zero_index_and_signal_monitor

// ===== verification/zism_counter_model.sv
// Behavioural external counter reading the incremental A/B/Z lines.
// Assumes it is in standby from reset, so only later moves are counted.
`timescale 1ns/10ps
module zism_counter_model (
    // Clock and reset
    input  wire logic        clock_i,
    input  wire logic        rst_n_i,
    // Incremental lines
    input  wire logic        a_i,
    input  wire logic        b_i,
    input  wire logic        z_i,
    // Count seen
    output logic      [23:0] count_o
);
    logic a_r, b_r;
    always_ff @(posedge clock_i) begin
        a_r <= a_i;
        b_r <= b_i;
        if (!rst_n_i || z_i) count_o <= 24'h000000;
        else if ((a_i ^ a_r) || (b_i ^ b_r)) count_o <= (a_i ^ b_r) ? count_o + 24'h1 : count_o - 24'h1;
    end
endmodule : zism_counter_model
